// file: design/ebc_bus_ctrl.sv
// Purpose: external bus control pins of the processor: selects, strobes, ready, hold
// Assumes: core requests one external transfer at a time; ready_in synchronous
// Notes:   off_n_in floats outputs combinationally, so it works even during reset
//
// What this block does
// - data select low only for data-space access
// - io select low only for I/O access
// - ready low: wait a cycle, sample again
// - read/write rests high, low only writing
// - read strobe low on every external read
// - write strobe low on writes, data driven
// - bus cycle strobe low only during cycle
// - bus request low on global data access
// - hold floats bus, asserts hold acknowledge
// - external flag is software latched level
// - branch taken when condition input low
// - general pins not in handshake mode come up as inputs
// - general pins: software or handshake lines
// - output disable low floats every output
// - data bus floats unless writing, or reset
`timescale 1ns/100ps
module ebc_bus_ctrl (
   input  wire logic                        clk_in,
   input  wire logic                        sys_rst_in,
   input  wire logic                        off_n_in,
   input  wire logic                        req_in,
   input  wire logic [1:0]                  req_space_in,
   input  wire logic                        req_write_in,
   input  wire logic                        req_global_in,
   input  wire logic [ebc_pkg::ADDR_W-1:0]  req_addr_in,
   input  wire logic [ebc_pkg::DATA_W-1:0]  req_wdata_in,
   output logic                             req_ready_out,
   output logic                             done_out,
   output logic      [ebc_pkg::DATA_W-1:0]  rdata_out,
   input  wire logic                        ready_in,
   input  wire logic                        hold_req_in,
   input  wire logic                        flag_set_in,
   input  wire logic                        flag_clr_in,
   input  wire logic                        branch_poll_in,
   input  wire logic                        branch_condition_input_in,
   output logic                             branch_take_out,
   input  wire logic [ebc_pkg::DATA_W-1:0]  data_bus_lines_in,
   output logic      [ebc_pkg::DATA_W-1:0]  data_bus_lines_out,
   output logic                             data_bus_lines_oe_out,
   output logic      [ebc_pkg::ADDR_W-1:0]  addr_out,
   output logic                             program_space_select_n_out,
   output logic                             data_space_select_n_out,
   output logic                             io_space_select_n_out,
   output logic                             read_write_out,
   output logic                             read_strobe_n_out,
   output logic                             write_strobe_n_out,
   output logic                             bus_cycle_strobe_n_out,
   output logic                             ctl_oe_out,
   output logic                             global_bus_request_n_out,
   output logic                             hold_acknowledge_out,
   output logic                             external_flag_output_out,
   output logic                             mp_oe_out,
   input  wire logic                        gp_dir_wr_in,
   input  wire logic [ebc_pkg::GP_N-1:0]    gp_dir_in,
   input  wire logic                        gp_val_wr_in,
   input  wire logic [ebc_pkg::GP_N-1:0]    gp_val_in,
   input  wire logic [ebc_pkg::GP_N-1:0]    gp_hs_sel_in,
   input  wire logic [ebc_pkg::GP_N-1:0]    gp_hs_dir_in,
   input  wire logic [ebc_pkg::GP_N-1:0]    gp_hs_val_in,
   input  wire logic [ebc_pkg::GP_N-1:0]    general_purpose_pins_in,
   output logic      [ebc_pkg::GP_N-1:0]    general_purpose_pins_out,
   output logic      [ebc_pkg::GP_N-1:0]    general_purpose_pins_oe_out,
   output logic      [ebc_pkg::GP_N-1:0]    gp_read_out
);
   ebc_pkg::ebc_state_t              state_q, state_d;
   ebc_pkg::ebc_space_t              space_q, space_d;
   logic                             write_q, write_d, glob_q, glob_d;
   logic [ebc_pkg::ADDR_W-1:0]       addr_q, addr_d;
   logic [ebc_pkg::DATA_W-1:0]       wdata_q, wdata_d, rdata_q, rdata_d;
   logic                             done_q, done_d;
   logic                             ps_q, ps_d, ds_q, ds_d, is_q, is_d;
   logic                             rw_q, rw_d, rd_q, rd_d, we_q, we_d, bus_cycle_strobe_q, bus_cycle_strobe_d;
   logic                             br_q, br_d, dboe_q, dboe_d, hold_q, hold_d;
   logic                             xf_q, xf_d, brt_q, brt_d;
   logic                             take;

   // one decode for all three selects, so two can never be low together
   function automatic logic sel_n(input ebc_pkg::ebc_state_t st,
                                  input ebc_pkg::ebc_space_t sp,
                                  input ebc_pkg::ebc_space_t want);
      sel_n = !(st == ebc_pkg::EBC_ACCESS && sp == want);
   endfunction

   assign take          = req_in && state_q == ebc_pkg::EBC_IDLE && !hold_req_in;
   assign req_ready_out = state_q == ebc_pkg::EBC_IDLE && !hold_req_in;

   // bus sequencer: next state, latched request and pin levels
   always_comb begin
      state_d = state_q;
      space_d = space_q;
      write_d = write_q;
      glob_d  = glob_q;
      addr_d  = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      done_d  = 1'h0;
      unique case (state_q)
         ebc_pkg::EBC_IDLE: begin
            if (hold_req_in) begin
               state_d = ebc_pkg::EBC_HOLD;
            end else if (req_in) begin
               state_d = ebc_pkg::EBC_ACCESS;
               space_d = ebc_pkg::ebc_space_t'(req_space_in);
               write_d = req_write_in;
               glob_d  = req_global_in && req_space_in == 2'h1;
               addr_d  = req_addr_in;
               wdata_d = req_wdata_in;
            end
         end
         ebc_pkg::EBC_ACCESS: begin
            // ready low keeps the cycle going and samples again next cycle
            if (ready_in) begin
               state_d = ebc_pkg::EBC_FINISH;
               done_d  = 1'h1;
               if (!write_q) begin
                  rdata_d = data_bus_lines_in;
               end
            end
         end
         ebc_pkg::EBC_FINISH: begin
            state_d = ebc_pkg::EBC_IDLE;
         end
         ebc_pkg::EBC_HOLD: begin
            if (!hold_req_in) begin
               state_d = ebc_pkg::EBC_IDLE;
            end
         end
      endcase
      ps_d   = sel_n(state_d, space_d, ebc_pkg::EBC_SP_PROG);
      ds_d   = sel_n(state_d, space_d, ebc_pkg::EBC_SP_DATA);
      is_d   = sel_n(state_d, space_d, ebc_pkg::EBC_SP_IO);
      bus_cycle_strobe_d = state_d != ebc_pkg::EBC_ACCESS;
      rd_d   = !(state_d == ebc_pkg::EBC_ACCESS && !write_d);
      we_d   = !(state_d == ebc_pkg::EBC_ACCESS && write_d);
      // write data held one cycle past the strobe rising edge for the latch
      dboe_d = write_d && (state_d == ebc_pkg::EBC_ACCESS
                           || state_d == ebc_pkg::EBC_FINISH);
      rw_d   = !dboe_d;
      br_d   = !(state_d == ebc_pkg::EBC_ACCESS && glob_d);
      hold_d = state_d == ebc_pkg::EBC_HOLD;
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_q <= ebc_pkg::EBC_IDLE;
         space_q <= ebc_pkg::EBC_SP_PROG;
         write_q <= 1'h0;
         glob_q  <= 1'h0;
         addr_q  <= '0;
         wdata_q <= '0;
         rdata_q <= '0;
         done_q  <= 1'h0;
         ps_q    <= ebc_pkg::PIN_IDLE;
         ds_q    <= ebc_pkg::PIN_IDLE;
         is_q    <= ebc_pkg::PIN_IDLE;
         bus_cycle_strobe_q  <= ebc_pkg::PIN_IDLE;
         rd_q    <= ebc_pkg::PIN_IDLE;
         we_q    <= ebc_pkg::PIN_IDLE;
         rw_q    <= ebc_pkg::PIN_IDLE;
         br_q    <= ebc_pkg::PIN_IDLE;
         dboe_q  <= 1'h0;
         hold_q  <= 1'h0;
      end else begin
         state_q <= state_d;
         space_q <= space_d;
         write_q <= write_d;
         glob_q  <= glob_d;
         addr_q  <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         done_q  <= done_d;
         ps_q    <= ps_d;
         ds_q    <= ds_d;
         is_q    <= is_d;
         bus_cycle_strobe_q  <= bus_cycle_strobe_d;
         rd_q    <= rd_d;
         we_q    <= we_d;
         rw_q    <= rw_d;
         br_q    <= br_d;
         dboe_q  <= dboe_d;
         hold_q  <= hold_d;
      end
   end

   // flag and branch test; set beats clear when both arrive together
   always_comb begin
      xf_d  = flag_set_in ? 1'h1 : (flag_clr_in ? 1'h0 : xf_q);
      brt_d = branch_poll_in && !branch_condition_input_in;
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         xf_q  <= ebc_pkg::XF_RST;
         brt_q <= 1'h0;
      end else begin
         xf_q  <= xf_d;
         brt_q <= brt_d;
      end
   end

   assign done_out                   = done_q;
   assign rdata_out                  = rdata_q;
   assign branch_take_out            = brt_q;
   assign addr_out                   = addr_q;
   assign data_bus_lines_out         = wdata_q;
   assign data_bus_lines_oe_out      = dboe_q && !sys_rst_in && off_n_in;
   assign program_space_select_n_out = ps_q;
   assign data_space_select_n_out    = ds_q;
   assign io_space_select_n_out      = is_q;
   assign read_write_out             = rw_q;
   assign read_strobe_n_out          = rd_q;
   assign write_strobe_n_out         = we_q;
   assign bus_cycle_strobe_n_out     = bus_cycle_strobe_q;
   assign global_bus_request_n_out   = br_q;
   assign ctl_oe_out                 = off_n_in && !hold_q;
   assign hold_acknowledge_out       = hold_q;
   assign external_flag_output_out   = xf_q;
   assign mp_oe_out                  = off_n_in;

   ebc_gpio u_gpio (
      .clk_in      (clk_in),
      .sys_rst_in  (sys_rst_in),
      .off_n_in    (off_n_in),
      .dir_wr_in   (gp_dir_wr_in),
      .dir_in      (gp_dir_in),
      .val_wr_in   (gp_val_wr_in),
      .val_in      (gp_val_in),
      .hs_sel_in   (gp_hs_sel_in),
      .hs_dir_in   (gp_hs_dir_in),
      .hs_val_in   (gp_hs_val_in),
      .pin_in      (general_purpose_pins_in),
      .pin_out     (general_purpose_pins_out),
      .pin_oe_out  (general_purpose_pins_oe_out),
      .pin_val_out (gp_read_out)
   );

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_read_start;
      take && !req_write_in;
   endsequence
   sequence s_wait;
      state_q == ebc_pkg::EBC_ACCESS && !ready_in;
   endsequence

   a_ds_only_data: assert property (!ds_q |-> state_q == ebc_pkg::EBC_ACCESS
      && space_q == ebc_pkg::EBC_SP_DATA) else $error("data select low outside data access");
   a_is_only_io: assert property (!is_q |-> state_q == ebc_pkg::EBC_ACCESS
      && space_q == ebc_pkg::EBC_SP_IO) else $error("io select low outside io access");
   a_ready_wait: assert property (s_wait |=> state_q == ebc_pkg::EBC_ACCESS
      && !bus_cycle_strobe_q && !done_q) else $error("cycle ended while ready low");
   a_ready_done: assert property (state_q == ebc_pkg::EBC_ACCESS && ready_in
      |=> done_q && bus_cycle_strobe_q ##1 state_q == ebc_pkg::EBC_IDLE) else $error("ready not honoured");
   a_rw_write_only: assert property (!rw_q |-> write_q
      && state_q inside {ebc_pkg::EBC_ACCESS, ebc_pkg::EBC_FINISH})
      else $error("rw low not writing");
   a_read_strobe: assert property (s_read_start |=> !rd_q && we_q && rw_q)
      else $error("read strobe missing");
   a_we_data_held: assert property ($rose(we_q) |-> dboe_q && !rw_q)
      else $error("data not driven at write strobe rise");
   a_strobe_cycle: assert property (!bus_cycle_strobe_q |-> state_q == ebc_pkg::EBC_ACCESS)
      else $error("strobe low outside bus cycle");
   a_br_global: assert property (take && req_global_in && req_space_in == 2'h1
      |=> !br_q && !ds_q) else $error("bus request missing on global access");
   a_hold_float: assert property (hold_req_in && state_q == ebc_pkg::EBC_IDLE
      |=> hold_acknowledge_out && !ctl_oe_out && !data_bus_lines_oe_out)
      else $error("hold not taken");
   a_xf_set: assert property (flag_set_in |=> external_flag_output_out)
      else $error("flag not set");
   a_branch_low: assert property (branch_poll_in && !branch_condition_input_in
      |=> branch_take_out) else $error("branch not taken");
   a_off_float: assert property (!off_n_in |-> !ctl_oe_out && !mp_oe_out
      && !data_bus_lines_oe_out && general_purpose_pins_oe_out == 4'h0)
      else $error("off not floating");
   a_data_float: assert property (rw_q |-> !data_bus_lines_oe_out)
      else $error("data bus driven while reading");
   a_one_select: assert property ($countones({~ps_q, ~ds_q, ~is_q}) <= 1)
      else $error("two space selects low");
endmodule

// file: design/ebc_pkg.sv
// Purpose: shared constants and types for the external bus control block
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes:   pin levels are named as driven on the wire (active-low strobes idle at 1)
package ebc_pkg;
   localparam int          DATA_W      = 16;
   localparam int          ADDR_W      = 16;
   localparam int          GP_N        = 4;
   localparam logic [3:0]  GP_DIR_RST  = 4'h0;
   localparam logic [3:0]  GP_VAL_RST  = 4'h0;
   localparam logic        XF_RST      = 1'h0;
   localparam logic        PIN_IDLE    = 1'h1;

   typedef enum logic [1:0] {
      EBC_SP_PROG,
      EBC_SP_DATA,
      EBC_SP_IO
   } ebc_space_t;

   typedef enum logic [1:0] {
      EBC_IDLE,
      EBC_ACCESS,
      EBC_FINISH,
      EBC_HOLD
   } ebc_state_t;
endpackage

// file: design/ebc_gpio.sv
// Purpose: four general-purpose pins, software or serial-handshake controlled
// Assumes: pin inputs synchronous to clk_in
// Notes:   direction and value registers come from the serial port control register
`timescale 1ns/100ps
module ebc_gpio (
   input  wire logic                      clk_in,
   input  wire logic                      sys_rst_in,
   input  wire logic                      off_n_in,
   input  wire logic                      dir_wr_in,
   input  wire logic [ebc_pkg::GP_N-1:0]  dir_in,
   input  wire logic                      val_wr_in,
   input  wire logic [ebc_pkg::GP_N-1:0]  val_in,
   input  wire logic [ebc_pkg::GP_N-1:0]  hs_sel_in,
   input  wire logic [ebc_pkg::GP_N-1:0]  hs_dir_in,
   input  wire logic [ebc_pkg::GP_N-1:0]  hs_val_in,
   input  wire logic [ebc_pkg::GP_N-1:0]  pin_in,
   output logic      [ebc_pkg::GP_N-1:0]  pin_out,
   output logic      [ebc_pkg::GP_N-1:0]  pin_oe_out,
   output logic      [ebc_pkg::GP_N-1:0]  pin_val_out
);
   logic [ebc_pkg::GP_N-1:0] dir_q, dir_d, val_q, val_d, rd_q, rd_d;

   always_comb begin
      dir_d = dir_wr_in ? dir_in : dir_q;
      val_d = val_wr_in ? val_in : val_q;
      rd_d  = pin_in;
   end

   // all pins under software control come up as inputs; handshake pins follow gp_hs_dir_in
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         dir_q <= ebc_pkg::GP_DIR_RST;
         val_q <= ebc_pkg::GP_VAL_RST;
         rd_q  <= ebc_pkg::GP_VAL_RST;
      end else begin
         dir_q <= dir_d;
         val_q <= val_d;
         rd_q  <= rd_d;
      end
   end

   generate
      for (genvar i = 0; i < ebc_pkg::GP_N; i++) begin : g_pin
         // per pin: software line or serial handshake line
         assign pin_out[i]    = hs_sel_in[i] ? hs_val_in[i] : val_q[i];
         assign pin_oe_out[i] = off_n_in & (hs_sel_in[i] ? hs_dir_in[i] : dir_q[i]);
      end
   endgenerate

   assign pin_val_out = rd_q;
endmodule

// file: dv/ebc_mem_model.sv
// Purpose: external memory and I/O device on the far side of the bus
// Assumes: strobes active low, one shared 16-word store for all spaces
// Notes:   released data lines show the inverse of their last value
`timescale 1ns/100ps
module ebc_mem_model (
   input  wire logic         clk_in,
   input  wire logic [2:0]   wait_in,
   input  wire logic [15:0]  addr_in,
   input  wire logic         rd_n_in,
   input  wire logic         wr_n_in,
   input  wire logic         strobe_n_in,
   input  wire logic         ctl_oe_in,
   input  wire logic [15:0]  dev_data_in,
   input  wire logic         dev_oe_in,
   output logic              ready_out,
   output logic      [15:0]  bus_out
);
   logic [15:0] mem [16];
   logic [2:0]  cnt_q;
   logic [3:0]  addr_q;
   logic [15:0] last_q;
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 16'h0000;
      end
      cnt_q = 3'h0;
      addr_q = 4'h0;
      last_q = 16'h0000;
   end
   // ready held low until the wait count has run out
   assign ready_out = (strobe_n_in || !ctl_oe_in) ? 1'b1 : (cnt_q >= wait_in);
   always @(posedge clk_in) begin
      cnt_q <= strobe_n_in ? 3'h0 : cnt_q + 3'h1;
      last_q <= bus_out;
   end
   // address taken mid-cycle, away from the edge where the pins move
   always @(negedge clk_in) begin
      if (!strobe_n_in) begin
         addr_q <= addr_in[3:0];
      end
   end
   always @(posedge wr_n_in) begin
      if (dev_oe_in) begin
         mem[addr_q] = bus_out;
      end
   end
   always_comb begin
      if (dev_oe_in) begin
         bus_out = dev_data_in;
      end else if (!rd_n_in && ctl_oe_in) begin
         bus_out = mem[addr_q];
      end else begin
         bus_out = ~last_q;
      end
   end
endmodule

// file: dv/ebc_bus_ctrl_bench.sv
// Purpose: self-checking bench for the external bus control block
// Assumes: far side is the memory model, addresses folded to 16 words
// Notes:   random traffic from a fixed seed plus hand-picked corners
`timescale 1ns/100ps
module ebc_bus_ctrl_bench;
   logic        clk_in, sys_rst_in, off_n_in, req_in, req_write_in, req_global_in;
   logic        req_ready_out, done_out, ready_in, hold_req_in, flag_set_in, flag_clr_in;
   logic        branch_poll_in, branch_condition_input_in, branch_take_out;
   logic        data_bus_lines_oe_out, program_space_select_n_out, data_space_select_n_out;
   logic        io_space_select_n_out, read_write_out, read_strobe_n_out;
   logic        write_strobe_n_out, bus_cycle_strobe_n_out, ctl_oe_out;
   logic        global_bus_request_n_out, hold_acknowledge_out, external_flag_output_out;
   logic        mp_oe_out, gp_dir_wr_in, gp_val_wr_in;
   logic [1:0]  req_space_in;
   logic [2:0]  wait_cnt;
   logic [15:0] req_addr_in, req_wdata_in, rdata_out, data_bus_lines_in;
   logic [15:0] data_bus_lines_out, addr_out;
   logic [3:0]  gp_dir_in, gp_val_in, gp_hs_sel_in, gp_hs_dir_in, gp_hs_val_in, gp_drv;
   logic [3:0]  general_purpose_pins_in, general_purpose_pins_out;
   logic [3:0]  general_purpose_pins_oe_out, gp_read_out;
   logic [15:0] shadow [16];
   int          err_total, total_checks;

   assign general_purpose_pins_in = (general_purpose_pins_oe_out & general_purpose_pins_out)
                                  | (~general_purpose_pins_oe_out & gp_drv);

   ebc_bus_ctrl u_ebc_bus_ctrl (.clk_in, .sys_rst_in, .off_n_in, .req_in, .req_space_in,
      .req_write_in, .req_global_in, .req_addr_in, .req_wdata_in, .req_ready_out, .done_out,
      .rdata_out, .ready_in, .hold_req_in, .flag_set_in, .flag_clr_in, .branch_poll_in,
      .branch_condition_input_in, .branch_take_out, .data_bus_lines_in, .data_bus_lines_out,
      .data_bus_lines_oe_out, .addr_out, .program_space_select_n_out,
      .data_space_select_n_out, .io_space_select_n_out, .read_write_out, .read_strobe_n_out,
      .write_strobe_n_out, .bus_cycle_strobe_n_out, .ctl_oe_out, .global_bus_request_n_out,
      .hold_acknowledge_out, .external_flag_output_out, .mp_oe_out, .gp_dir_wr_in,
      .gp_dir_in, .gp_val_wr_in, .gp_val_in, .gp_hs_sel_in, .gp_hs_dir_in, .gp_hs_val_in,
      .general_purpose_pins_in, .general_purpose_pins_out, .general_purpose_pins_oe_out,
      .gp_read_out);

   ebc_mem_model u_ebc_mem_model (.clk_in, .wait_in(wait_cnt), .addr_in(addr_out),
      .rd_n_in(read_strobe_n_out), .wr_n_in(write_strobe_n_out),
      .strobe_n_in(bus_cycle_strobe_n_out), .ctl_oe_in(ctl_oe_out),
      .dev_data_in(data_bus_lines_out), .dev_oe_in(data_bus_lines_oe_out),
      .ready_out(ready_in), .bus_out(data_bus_lines_in));

   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   // {prog, data, io} selects, all active low
   function automatic logic [2:0] exp_sel(input logic [1:0] sp);
      return ~(3'h4 >> sp);
   endfunction

   function automatic logic [7:0] pins();
      return {program_space_select_n_out, data_space_select_n_out, io_space_select_n_out,
              bus_cycle_strobe_n_out, read_write_out, read_strobe_n_out,
              write_strobe_n_out, global_bus_request_n_out};
   endfunction

   task automatic give_verdict;
      if (err_total == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic hang(input string what);
      err_total++;
      $display("ERROR %0t wait ran out: %s", $time, what);
      give_verdict();
   endtask

   task automatic xfer(input logic [1:0] sp, input logic wr, input logic gl,
                       input logic [15:0] a, input logic [15:0] d, input logic [2:0] w);
      int   n;
      logic br;
      br = !(gl && sp == 2'h1);
      @(posedge clk_in);
      req_in <= 1'b1;
      req_space_in <= sp;
      req_write_in <= wr;
      req_global_in <= gl;
      req_addr_in <= a;
      req_wdata_in <= d;
      wait_cnt <= w;
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
         if (n > 20) hang("request not taken");
      end while (req_ready_out !== 1'b1);
      @(posedge clk_in);
      req_in <= 1'b0;
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
         if (n > 20) hang("transfer not done");
         if (done_out !== 1'b1) begin
            chk(pins() >> 4, {exp_sel(sp), 1'b0}, "selects");
            chk(pins() & 8'hf, {!wr, wr, !wr, br}, "strobes");
            chk({data_bus_lines_oe_out, addr_out}, {wr, a}, "drive and address");
            if (wr) chk(data_bus_lines_out, d, "write data");
         end
      end while (done_out !== 1'b1);
      chk(20'(n), 20'(2 + w), "cycles to done");
      chk(pins() >> 1, {4'hf, !wr, 2'h3}, "finish pins");
      if (!wr) chk(rdata_out, shadow[a[3:0]], "read data");
      else shadow[a[3:0]] = d;
      @(negedge clk_in);
      chk({read_write_out, data_bus_lines_oe_out}, 2'h2, "bus released");
   endtask

   initial begin
      logic [3:0] eo, ev;
      logic [1:0] fc;
      err_total = 0;
      total_checks = 0;
      {sys_rst_in, off_n_in} = 2'h3;
      {req_in, req_write_in, req_global_in, hold_req_in, flag_set_in, flag_clr_in} = 6'h0;
      {branch_poll_in, branch_condition_input_in, gp_dir_wr_in, gp_val_wr_in} = 4'h0;
      {req_space_in, wait_cnt, req_addr_in, req_wdata_in} = 37'h0;
      {gp_dir_in, gp_val_in, gp_hs_sel_in, gp_hs_dir_in, gp_hs_val_in, gp_drv} = 24'h0;
      for (int i = 0; i < 16; i++) shadow[i] = 16'h0000;
      void'($urandom(32'h4a5a1ac4));
      repeat (2) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(negedge clk_in);
      chk({pins(), hold_acknowledge_out, external_flag_output_out, data_bus_lines_oe_out,
           general_purpose_pins_oe_out}, 15'h7f80, "reset levels");
      // every space in both directions, each space read before it is written, all to one word
      for (int i = 0; i < 6; i++) begin
         xfer(2'(i / 2), 1'(i), 1'b1, 16'h0005, 16'ha5c3 ^ 16'(i), 3'(i % 4));
      end
      for (int i = 0; i < 24; i++) begin
         xfer(2'($urandom_range(2)), 1'($urandom), 1'($urandom), 16'($urandom),
              16'($urandom), 3'($urandom_range(3)));
      end
      // set, clear, both together (set wins), clear
      for (int i = 0; i < 4; i++) begin
         fc = 2'(8'h76 >> (2 * i));
         @(posedge clk_in);
         {flag_set_in, flag_clr_in} <= fc;
         @(posedge clk_in);
         {flag_set_in, flag_clr_in} <= 2'h0;
         @(negedge clk_in);
         chk(external_flag_output_out, fc[1], "flag level");
      end
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_in);
         branch_poll_in <= 1'b1;
         branch_condition_input_in <= 1'(i ^ (i >> 2));
         @(posedge clk_in);
         branch_poll_in <= 1'b0;
         @(negedge clk_in);
         chk(branch_take_out, !1'(i ^ (i >> 2)), "branch taken");
      end
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_in);
         {gp_dir_wr_in, gp_val_wr_in} <= 2'h3;
         {gp_dir_in, gp_val_in, gp_hs_sel_in} <= 12'($urandom);
         {gp_hs_dir_in, gp_hs_val_in, gp_drv} <= 12'($urandom);
         @(posedge clk_in);
         {gp_dir_wr_in, gp_val_wr_in} <= 2'h0;
         @(posedge clk_in);
         @(negedge clk_in);
         eo = (gp_hs_sel_in & gp_hs_dir_in) | (~gp_hs_sel_in & gp_dir_in);
         ev = (gp_hs_sel_in & gp_hs_val_in) | (~gp_hs_sel_in & gp_val_in);
         chk({general_purpose_pins_oe_out, general_purpose_pins_out}, {eo, ev},
             "pins");
         chk(gp_read_out, (eo & ev) | (~eo & gp_drv), "pin input");
      end
      @(posedge clk_in);
      off_n_in <= 1'b0;
      @(negedge clk_in);
      chk({ctl_oe_out, mp_oe_out, data_bus_lines_oe_out, general_purpose_pins_oe_out}, 7'h0,
          "outputs floated");
      @(posedge clk_in);
      off_n_in <= 1'b1;
      hold_req_in <= 1'b1;
      @(posedge clk_in);
      @(negedge clk_in);
      chk({hold_acknowledge_out, ctl_oe_out, data_bus_lines_oe_out, req_ready_out}, 4'h8,
          "hold entered");
      @(posedge clk_in);
      hold_req_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk({hold_acknowledge_out, ctl_oe_out}, 2'h1, "hold left");
      // reset lands in the middle of a stretched write; held two edges so that
      // no edge-based check sees the strobe jump while reset is still settling
      @(posedge clk_in);
      {req_in, req_write_in, req_space_in, wait_cnt} <= {1'b1, 1'b1, 2'h1, 3'h3};
      @(posedge clk_in);
      req_in <= 1'b0;
      @(negedge clk_in);
      chk(data_bus_lines_oe_out, 1'b1, "write driving");
      @(posedge clk_in);
      sys_rst_in <= 1'b1;
      @(negedge clk_in);
      chk(data_bus_lines_oe_out, 1'b0, "bus held in reset");
      repeat (2) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(negedge clk_in);
      chk({pins(), hold_acknowledge_out, external_flag_output_out, data_bus_lines_oe_out,
           general_purpose_pins_oe_out}, {11'h7f8, gp_hs_sel_in & gp_hs_dir_in},
          "levels after reset");
      xfer(2'h1, 1'b0, 1'b1, 16'h0005, 16'h0000, 3'h2);
      give_verdict();
   end
endmodule
